//--- ocr_pkg.sv
package ocr_pkg;

  // ---------------------------------------------------------------------
  // Register map (word-aligned byte offsets).
  // ---------------------------------------------------------------------
  localparam logic [11:0] SEL_LO_OFF = 12'h000;
  localparam logic [11:0] SEL_HI_OFF = 12'h004;
  localparam logic [11:0] CODE_OFF = 12'h008;
  localparam logic [11:0] CTRL_OFF = 12'h00C;
  localparam logic [11:0] COUNT_OFF = 12'h010;
  localparam logic [11:0] TRIG_LO_OFF = 12'h014;
  localparam logic [11:0] TRIG_HI_OFF = 12'h018;
  localparam logic [11:0] NEXT_LO_OFF = 12'h01C;
  localparam logic [11:0] NEXT_HI_OFF = 12'h020;

  // ---------------------------------------------------------------------
  // Selection register fields.
  // ---------------------------------------------------------------------
  localparam int REQ_LSB = 0;
  localparam int REQ_W = 16;
  localparam int SUP_LSB = 16;
  localparam int SUP_W = 15;
  localparam int SNP_LSB = 31;
  localparam int SNP_W = 7;
  localparam int SEL_W = 38;

  localparam int SUP_ANY = 0;
  localparam int SUP_NONE = 1;
  localparam int SUP_HITM = 2;
  localparam int SUP_HITE = 3;
  localparam int SUP_HITS = 4;
  localparam int SUP_HOP0 = 11;
  localparam int SUP_HOP1 = 12;
  localparam int SUP_HOP2 = 13;

  // Request bits 14:12 are reserved.
  localparam logic [15:0] REQ_VALID_MASK = 16'h8FFF;
  // Supplier masks: bits 0..4 and 6 common, other upper bits per variant.
  localparam logic [14:0] SUP_MASK_CLIENT = 15'h005F;
  localparam logic [14:0] SUP_MASK_L4 = 15'h03DF;
  localparam logic [14:0] SUP_MASK_SERVER = 15'h387F;

  // Record offsets of the two instruction address fields.
  localparam logic [7:0] REC_TRIG_OFF = 8'hB0;
  localparam logic [7:0] REC_NEXT_OFF = 8'h08;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    VAR_CLIENT = 2'h0,
    VAR_L4 = 2'h1,
    VAR_SERVER = 2'h2
  } variant_e;

  typedef struct packed {
    logic valid;
    logic [REQ_W-1:0] req;
    logic [SUP_W-1:0] sup;
    logic [SNP_W-1:0] snp;
  } response_s;

  typedef struct packed {
    logic valid;
    logic [7:0] offset;
    logic [63:0] addr;
  } record_write_s;

endpackage : ocr_pkg

//--- offcore_response_filter.sv
`timescale 1ns/10ps
`default_nettype none
module offcore_response_filter
  import ocr_pkg::*;
#(
  parameter int NUM_CODES = 2,
  parameter variant_e VARIANT = VAR_CLIENT,
  parameter int COUNT_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire response_s rsp_in,
  input wire logic [$clog2(NUM_CODES)-1:0] rsp_code,
  output logic match_pulse,
  input wire logic sample_assist,
  input wire logic [63:0] trigger_instr_address,
  input wire logic [63:0] next_instr_address,
  output record_write_s trig_rec,
  output record_write_s next_rec
);

  localparam int CW = $clog2(NUM_CODES);

  // The code register indexes the selection array directly, so a count
  // that is not a power of two would let software pick a missing entry.
  if (NUM_CODES < 2 || NUM_CODES > 16 ||
      (1 << CW) != NUM_CODES) begin : g_bad_codes
    $error("NUM_CODES must be a power of two from 2 to 16.");
  end
  if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
    $error("COUNT_W must lie between 1 and 32.");
  end

  // ---------------------------------------------------------------------
  // Writable masks.
  // ---------------------------------------------------------------------
  // Unimplemented supplier bits never store, so they read back as zero
  // and cannot leak into the filter.
  localparam logic [14:0] SUP_MASK = (VARIANT == VAR_SERVER) ?
      SUP_MASK_SERVER : (VARIANT == VAR_L4) ? SUP_MASK_L4 : SUP_MASK_CLIENT;
  localparam logic [SEL_W-1:0] SEL_MASK = {7'h7F, SUP_MASK, REQ_VALID_MASK};

  logic [SEL_W-1:0] sel_q [NUM_CODES];
  logic [CW-1:0] code_q;
  logic count_en_q;
  logic [COUNT_W-1:0] count_q;
  logic match_q;
  logic [63:0] trig_cap_q;
  logic [63:0] next_cap_q;
  record_write_s trig_rec_q;
  record_write_s next_rec_q;

  logic access;
  logic wr;
  logic [SEL_W-1:0] cur_sel;
  logic hit;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign cur_sel = sel_q[code_q];
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      SEL_LO_OFF, SEL_HI_OFF, CODE_OFF, CTRL_OFF, COUNT_OFF,
      TRIG_LO_OFF, TRIG_HI_OFF, NEXT_LO_OFF, NEXT_HI_OFF: pslverr = 1'b0;
      default: pslverr = access;
    endcase
  end

  // ---------------------------------------------------------------------
  // Selection registers, one per event code.
  // ---------------------------------------------------------------------
  for (genvar i = 0; i < NUM_CODES; i++) begin : g_sel
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sel_q[i] <= '0;
      end else if (wr && code_q == CW'(i)) begin
        if (paddr == SEL_LO_OFF) begin
          sel_q[i][31:0] <= pwdata & SEL_MASK[31:0];
        end else if (paddr == SEL_HI_OFF) begin
          sel_q[i][SEL_W-1:32] <= pwdata[SEL_W-33:0] &
              SEL_MASK[SEL_W-1:32];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= '0;
      count_en_q <= 1'b0;
    end else if (wr && paddr == CODE_OFF) begin
      code_q <= pwdata[CW-1:0];
    end else if (wr && paddr == CTRL_OFF) begin
      count_en_q <= pwdata[0];
    end
  end

  // ---------------------------------------------------------------------
  // Response filter.
  // ---------------------------------------------------------------------
  // Each request bit names one class (bit 0 demand data, 1 ownership,
  // 2 code, 3 writeback, 4-6 and 7-9 prefetcher classes, 10 locks,
  // 11 streaming stores, 15 other); the response carries its class one-hot.
  // Software must program the code's register before enabling.
  logic req_hit;
  logic sup_hit;
  logic snp_hit;
  assign req_hit = |(rsp_in.req & cur_sel[REQ_LSB+:REQ_W]);
  assign sup_hit = cur_sel[SUP_LSB+SUP_ANY] ||
      (|(rsp_in.sup & cur_sel[SUP_LSB+:SUP_W]));
  assign snp_hit = |(rsp_in.snp & cur_sel[SNP_LSB+:SNP_W]);
  assign hit = rsp_in.valid && rsp_code == code_q && count_en_q &&
      req_hit && sup_hit && snp_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      match_q <= 1'b0;
    end else begin
      match_q <= hit;
      if (wr && paddr == COUNT_OFF) begin
        count_q <= pwdata[COUNT_W-1:0];
      end else if (hit) begin
        count_q <= count_q + 1'b1;
      end
    end
  end
  assign match_pulse = match_q;

  // ---------------------------------------------------------------------
  // Precise sample record fields.
  // ---------------------------------------------------------------------
  // The two addresses differ: one is the retired trigger, the other is
  // where execution resumes after the assist.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_rec_q <= '0;
      next_rec_q <= '0;
      trig_cap_q <= '0;
      next_cap_q <= '0;
    end else begin
      trig_rec_q.valid <= sample_assist;
      next_rec_q.valid <= sample_assist;
      if (sample_assist) begin
        trig_rec_q.offset <= REC_TRIG_OFF;
        trig_rec_q.addr <= trigger_instr_address;
        next_rec_q.offset <= REC_NEXT_OFF;
        next_rec_q.addr <= next_instr_address;
        trig_cap_q <= trigger_instr_address;
        next_cap_q <= next_instr_address;
      end
    end
  end
  assign trig_rec = trig_rec_q;
  assign next_rec = next_rec_q;

  // ---------------------------------------------------------------------
  // Read data.
  // ---------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        SEL_LO_OFF: prdata <= cur_sel[31:0];
        SEL_HI_OFF: prdata <= {26'h0, cur_sel[SEL_W-1:32]};
        CODE_OFF: prdata <= 32'(code_q);
        CTRL_OFF: prdata <= {31'h0, count_en_q};
        COUNT_OFF: prdata <= 32'(count_q);
        TRIG_LO_OFF: prdata <= trig_cap_q[31:0];
        TRIG_HI_OFF: prdata <= trig_cap_q[63:32];
        NEXT_LO_OFF: prdata <= next_cap_q[31:0];
        NEXT_HI_OFF: prdata <= next_cap_q[63:32];
        default: prdata <= ZERO_WORD;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------
  // Every qualifier but the three fields (request, supplier, snoop), gathered once: valid, code, enable.
  logic qual_base;
  assign qual_base = rsp_in.valid && rsp_code == code_q && count_en_q;

  a_filter_count_step: assert property (
      @(posedge pclk) disable iff (!presetn)
      hit && !wr |=> count_q == $past(count_q) + 1'b1)
    else $error("Counter did not step on a match.");

  a_no_match_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !hit && !wr |=> count_q == $past(count_q))
    else $error("Counter moved without a match.");

  a_count_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == COUNT_OFF |=> count_q == $past(pwdata[COUNT_W-1:0]))
    else $error("Counter load did not take the written value.");

  a_pulse_follows: assert property (
      @(posedge pclk) disable iff (!presetn)
      match_pulse == $past(hit))
    else $error("Match pulse does not follow the counted response.");

  a_match_needs_req: assert property (
      @(posedge pclk) disable iff (!presetn)
      match_pulse |-> $past(|(rsp_in.req & cur_sel[REQ_LSB+:REQ_W])))
    else $error("Match without a request bit.");

  a_reserved_req_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cur_sel[REQ_LSB+:REQ_W] & ~REQ_VALID_MASK) == '0)
    else $error("Reserved request bits hold ones.");

  a_any_supplier: assert property (
      @(posedge pclk) disable iff (!presetn)
      cur_sel[SUP_LSB+SUP_ANY] && qual_base && req_hit && snp_hit |-> hit)
    else $error("Catch-all supplier bit failed to match.");

  // ---------------------------------------------------------------------
  // Gate checks.
  // ---------------------------------------------------------------------
  // Each qualifier alone must be able to veto a count; a match that
  // slipped past any one of them would inflate the counter silently.
  a_request_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !req_hit |-> !hit)
    else $error("Match without request bit.");

  a_supplier_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sup_hit |-> !hit)
    else $error("Match without supplier bit.");

  a_snoop_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !snp_hit |-> !hit)
    else $error("Match without snoop bit.");

  a_enable_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !count_en_q |-> !hit)
    else $error("Match while counting is off.");

  a_code_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      rsp_code != code_q |-> !hit)
    else $error("Match for another event code.");

  a_full_match: assert property (
      @(posedge pclk) disable iff (!presetn)
      qual_base && req_hit && sup_hit && snp_hit |-> hit)
    else $error("Qualified response was not counted.");

  // ---------------------------------------------------------------------
  // Per-bit filter checks.
  // ---------------------------------------------------------------------
  // With every other qualifier met, a one-hot response counts exactly
  // when its own selection bit is set, or for a supplier class when the
  // catch-all SUP_ANY bit is set. Reserved request bits never store, so
  // their classes can never count; reserved supplier classes count only
  // through SUP_ANY.
  for (genvar b = 0; b < REQ_W; b++) begin : g_req_chk
    a_req_class: assert property (
        @(posedge pclk) disable iff (!presetn)
        qual_base && sup_hit && snp_hit &&
        rsp_in.req == (REQ_W'(1) << b) |->
        hit == cur_sel[REQ_LSB+b])
      else $error("Request class filter disagrees with its bit.");
  end

  for (genvar s = 0; s < SUP_W; s++) begin : g_sup_chk
    a_sup_class: assert property (
        @(posedge pclk) disable iff (!presetn)
        qual_base && req_hit && snp_hit &&
        rsp_in.sup == (SUP_W'(1) << s) |->
        hit == (cur_sel[SUP_LSB+s] || cur_sel[SUP_LSB+SUP_ANY]))
      else $error("Supplier class filter disagrees with its bit.");
  end

  for (genvar p = 0; p < SNP_W; p++) begin : g_snp_chk
    a_snp_class: assert property (
        @(posedge pclk) disable iff (!presetn)
        qual_base && req_hit && sup_hit &&
        rsp_in.snp == (SNP_W'(1) << p) |->
        hit == cur_sel[SNP_LSB+p])
      else $error("Snoop class filter disagrees with its bit.");
  end

  // ---------------------------------------------------------------------
  // Selection register checks.
  // ---------------------------------------------------------------------
  // The variant decides which supplier bits exist; anything else must
  // drop on the way in, or it would widen the filter unseen.
  a_sup_reserved: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cur_sel[SUP_LSB+:SUP_W] & ~SUP_MASK) == '0)
    else $error("Unsupported supplier bit stored.");

  a_sel_low_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == SEL_LO_OFF |=>
      cur_sel[31:0] == ($past(pwdata) & SEL_MASK[31:0]))
    else $error("Low selection word did not store as masked.");

  a_sel_high_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && paddr == SEL_HI_OFF |=>
      cur_sel[SEL_W-1:32] ==
      ($past(pwdata[SEL_W-33:0]) & SEL_MASK[SEL_W-1:32]))
    else $error("High selection word did not store as masked.");

  a_sel_high_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == SEL_HI_OFF |=>
      prdata[31:SEL_W-32] == '0)
    else $error("Unused high selection bits read as ones.");

  // ---------------------------------------------------------------------
  // Record checks.
  // ---------------------------------------------------------------------
  a_trig_record: assert property (
      @(posedge pclk) disable iff (!presetn)
      sample_assist |=> trig_rec.valid && trig_rec.offset == REC_TRIG_OFF &&
      trig_rec.addr == $past(trigger_instr_address))
    else $error("Trigger address record wrong.");

  a_next_record: assert property (
      @(posedge pclk) disable iff (!presetn)
      sample_assist |=> next_rec.valid && next_rec.offset == REC_NEXT_OFF &&
      next_rec.addr == $past(next_instr_address))
    else $error("Next address record wrong.");

  // A record write without an assist would plant a stale address in the
  // sample buffer.
  a_record_idle: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sample_assist |=> !trig_rec.valid && !next_rec.valid)
    else $error("Record written without an assist.");

  a_capture_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sample_assist |=> $stable(trig_cap_q) && $stable(next_cap_q))
    else $error("Captured addresses changed without an assist.");

endmodule : offcore_response_filter
`default_nettype wire

//--- offcore_response_filter_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  $display("unexpected %s: expected %h, seen %h", n, e, g); \
  num_errors++; end end
module offcore_response_filter_test;
  import ocr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  response_s rsp_in = '0;
  logic [0:0] rsp_code = 1'b0;
  logic match_pulse;
  logic sample_assist = 1'b0;
  logic [63:0] trigger_instr_address = 64'h0;
  logic [63:0] next_instr_address = 64'h0;
  record_write_s trig_rec;
  record_write_s next_rec;
  int num_errors = 0;
  int checks = 0;
  int exp_cnt = 0;
  logic [31:0] rd;
  logic err;
  always #2 pclk = ~pclk;
  offcore_response_filter i_offcore_response_filter (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rsp_in(rsp_in), .rsp_code(rsp_code),
    .match_pulse(match_pulse), .sample_assist(sample_assist),
    .trigger_instr_address(trigger_instr_address),
    .next_instr_address(next_instr_address), .trig_rec(trig_rec),
    .next_rec(next_rec));
  // ---------------------------------------------------------------
  // Bus and stimulus tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // A matching response must pulse exactly once, one cycle later.
  task automatic rsp(input logic [15:0] q, input logic [14:0] s,
                     input logic [6:0] p, input logic e);
    @(posedge pclk);
    rsp_in <= '{1'b1, q, s, p};
    @(posedge pclk);
    rsp_in.valid <= 1'b0;
    #1;
    `CHK("match_pulse", e, match_pulse)
    if (e) exp_cnt++;
  endtask : rsp
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_fields;
    apb(1, SEL_LO_OFF, 32'hFFFF_FFFF);
    apb(0, SEL_LO_OFF, 0);
    `CHK("sel_lo", 32'h805F_8FFF, rd)
    apb(1, SEL_HI_OFF, 32'hFFFF_FFFF);
    apb(0, SEL_HI_OFF, 0);
    `CHK("sel_hi", 32'h0000_003F, rd)
    apb(1, SEL_HI_OFF, 32'h0);
  endtask : t_fields
  task automatic t_req_bits;
    int b;
    int bits[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 15};
    foreach (bits[i]) begin
      b = bits[i];
      apb(1, SEL_LO_OFF, 32'h8004_0000 | (32'h1 << b));
      rsp(16'h1 << b, 15'h0004, 7'h01, 1'b1);
      rsp(16'h1 << ((b + 1) % 16), 15'h0004, 7'h01, 1'b0);
    end
    apb(1, SEL_LO_OFF, 32'h8004_1000);
    rsp(16'h1000, 15'h0004, 7'h01, 1'b0);
  endtask : t_req_bits
  task automatic t_supplier;
    apb(1, SEL_LO_OFF, 32'h8001_0001);
    rsp(16'h0001, 15'h0010, 7'h01, 1'b1);
    for (int i = 1; i <= 4; i++) begin
      apb(1, SEL_LO_OFF, 32'h8000_0001 | (32'h1 << (16 + i)));
      rsp(16'h0001, 15'h1 << i, 7'h01, 1'b1);
      rsp(16'h0001, 15'h1 << (i % 4 + 1), 7'h01, 1'b0);
    end
  endtask : t_supplier
  task automatic t_gate;
    apb(1, SEL_LO_OFF, 32'h8004_0001);
    apb(1, CTRL_OFF, 32'h0);
    rsp(16'h0001, 15'h0004, 7'h01, 1'b0);
    apb(1, CTRL_OFF, 32'h1);
    @(posedge pclk);
    rsp_code <= 1'b1;
    rsp(16'h0001, 15'h0004, 7'h01, 1'b0);
    @(posedge pclk);
    rsp_code <= 1'b0;
    apb(1, CODE_OFF, 32'h1);
    apb(0, SEL_LO_OFF, 0);
    `CHK("sel_lo_code1", 32'h0000_0000, rd)
    apb(1, CODE_OFF, 32'h0);
    apb(1, COUNT_OFF, 32'h0000_0005);
    apb(0, COUNT_OFF, 0);
    `CHK("count_load", 32'h0000_0005, rd)
    exp_cnt = 5;
  endtask : t_gate
  task automatic t_snoop;
    apb(1, SEL_LO_OFF, 32'h0004_0001);
    apb(1, SEL_HI_OFF, 32'h0000_0001);
    rsp(16'h0001, 15'h0004, 7'h02, 1'b1);
    rsp(16'h0001, 15'h0004, 7'h01, 1'b0);
    apb(0, COUNT_OFF, 0);
    `CHK("count", exp_cnt, rd)
  endtask : t_snoop
  task automatic t_record;
    @(posedge pclk);
    trigger_instr_address <= 64'h0123_4567_89AB_CDEF;
    next_instr_address <= 64'hFEDC_BA98_7654_3210;
    sample_assist <= 1'b1;
    @(posedge pclk);
    sample_assist <= 1'b0;
    #1;
    `CHK("trig_rec", {1'b1, 8'hB0, 64'h0123_4567_89AB_CDEF}, trig_rec)
    `CHK("next_rec", {1'b1, 8'h08, 64'hFEDC_BA98_7654_3210}, next_rec)
    apb(0, TRIG_LO_OFF, 0);
    `CHK("trig_lo", 32'h89AB_CDEF, rd)
    apb(0, NEXT_HI_OFF, 0);
    `CHK("next_hi", 32'hFEDC_BA98, rd)
  endtask : t_record
  task automatic t_unmapped;
    apb(0, 12'h100, 0);
    `CHK("pslverr", 1'b1, err)
    `CHK("unmapped", 32'h0000_0000, rd)
  endtask : t_unmapped
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, CODE_OFF, 32'h0);
    apb(1, CTRL_OFF, 32'h1);
    t_fields();
    t_req_bits();
    t_supplier();
    t_gate();
    t_snoop();
    t_record();
    t_unmapped();
    stop_test();
  end
endmodule : offcore_response_filter_test
`default_nettype wire
